// ---- rtl/adc_frame_pkg.sv ----
// Shared constants and types for the converter's serial frame interface.
// Assumes a single 250 MHz system clock; all pin timing is recovered by sampling.
package adc_frame_pkg;

  // Clock and conversion timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_CONV_NS = 700;
  // Least time, so round up to whole cycles
  localparam int CONV_CYCLES = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

  // Frame geometry
  localparam int WORD_W = 32;
  localparam int NUM_LANES = 4;
  localparam int EDGE_CNT_W = 6;
  localparam logic [EDGE_CNT_W-1:0] EDGE_WORD = 6'h20;
  localparam logic [EDGE_CNT_W-1:0] EDGE_SAT = 6'h21;

  // Command word fields
  localparam int OP_W = 5;
  localparam int ADDR_W = 9;
  localparam int HALF_W = 16;
  localparam logic [WORD_W-1:0] CMD_NOP = 32'h0000_0000;
  localparam logic [OP_W-1:0] OP_CLEAR_HALF_WORD_OP = 5'h18;
  localparam logic [OP_W-1:0] OP_HALF_WORD_READ = 5'h19;
  localparam logic [OP_W-1:0] OP_READ_BYTE = 5'h09;
  localparam logic [OP_W-1:0] OP_WRITE_HALF_WORD_OP = 5'h1a;

  // Register space: 256 half-words addressed by address bits [8:1]
  localparam int REG_IDX_W = 8;
  localparam int REG_DEPTH = 256;
  localparam logic [HALF_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_IDX_W-1:0] CFG_IDX = 8'h00;
  localparam int CFG_RV_MODE_BIT = 0;

  typedef struct packed {
    logic [OP_W-1:0] opcode;
    logic [1:0] spare;
    logic [ADDR_W-1:0] addr;
    logic [HALF_W-1:0] data;
  } cmd_t;

  typedef enum logic [1:0] {
    FRAME_SHORT,
    FRAME_EXACT,
    FRAME_LONG
  } frame_kind_t;

  typedef struct packed {
    logic convert_select_n;
    logic serial_clk;
    logic serial_in;
  } link_pins_t;

endpackage : adc_frame_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser with edge detection for a group of asynchronous pins.
// Edges are taken from the second and third stages only; the first stage feeds nothing else.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : pin_sync

`default_nettype wire

// ---- rtl/adc_serial_frame_interface.sv ----
// Serial frame logic of a single-channel sampling converter: shift registers,
// edge counting, frame classification, command decode and conversion timing.
// Assumes the host drives select, serial clock and data asynchronously to sys_clk,
// with serial clock slow enough (80 ns) to be found by sampling.
`timescale 1ns/100ps
`default_nettype none

module adc_serial_frame_interface
  import adc_frame_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convert_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic [NUM_LANES-1:0] lane_enable,
  input wire logic [HALF_W-1:0] conv_data,
  output logic ready_valid_out,
  output logic [NUM_LANES-1:0] serial_out_lanes,
  output logic [NUM_LANES-1:0] serial_out_oe,
  output logic cmd_valid,
  output cmd_t cmd_word,
  output frame_kind_t frame_kind
);

  typedef enum logic [1:0] {
    ST_ACQ,
    ST_FRAME,
    ST_CONV
  } state_t;

  link_pins_t pins;
  link_pins_t pins_level;
  link_pins_t pins_rise;
  link_pins_t pins_fall;

  assign pins = '{convert_select_n: convert_select_n, serial_clk: serial_clk,
                  serial_in: serial_in};

  pin_sync #(
    .W($bits(link_pins_t))
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in(pins),
    .level(pins_level),
    .rise(pins_rise),
    .fall(pins_fall)
  );

  // The sync flops reset low while select idles high, so the first cycles after
  // reset show a false select rise; edges are ignored until the pipeline refills
  logic [1:0] settle_q, settle_d;
  logic armed;

  always_comb begin
    settle_d = settle_q;
    if (settle_q != '1) begin
      settle_d = settle_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settle_q <= '0;
    end else begin
      settle_q <= settle_d;
    end
  end

  assign armed = (settle_q == '1);

  logic cs_fall;
  logic cs_rise;
  logic launch_edge;
  logic capture_edge;

  assign cs_fall = pins_fall.convert_select_n & armed;
  assign cs_rise = pins_rise.convert_select_n & armed;
  // Mode 1 style link: launch on serial clock rise, capture on fall
  assign launch_edge = pins_rise.serial_clk & armed;
  assign capture_edge = pins_fall.serial_clk & armed;

  state_t state_q, state_d;
  logic rv_q, rv_d;
  logic [EDGE_CNT_W-1:0] edge_cnt_q, edge_cnt_d;
  logic [WORD_W-1:0] isr_q, isr_d;
  logic [WORD_W-1:0] output_shift_reg_q, output_shift_reg_d;
  logic [WORD_W-1:0] pending_q, pending_d;
  logic [NUM_LANES-1:0] lanes_q, lanes_d;
  logic [NUM_LANES-1:0] oe_q, oe_d;
  cmd_t hold_q, hold_d;
  logic cmd_valid_q, cmd_valid_d;
  frame_kind_t kind_q, kind_d;
  logic [CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d;
  logic [HALF_W-1:0] readback_q, readback_d;

  // Register space; written only by decoded frame commands
  logic [HALF_W-1:0] regs_q [REG_DEPTH];
  logic wr_en;
  logic [REG_IDX_W-1:0] wr_idx;
  logic [HALF_W-1:0] wr_val;
  logic [HALF_W-1:0] rd_half;
  logic rv_mode;

  // Half-word commands drop address bit 0, so an odd address hits the even entry
  assign wr_idx = hold_q.addr[REG_IDX_W:1];
  assign rd_half = regs_q[wr_idx];
  // Only bit 0 of entry 0 has a meaning here; the rest is plain storage
  assign rv_mode = regs_q[CFG_IDX][CFG_RV_MODE_BIT];

  // Frame class comes from the count alone, never from the data bits
  frame_kind_t end_kind;
  cmd_t end_cmd;

  always_comb begin
    end_kind = FRAME_LONG;
    end_cmd = isr_q;
    if (edge_cnt_q < EDGE_WORD) begin
      end_kind = FRAME_SHORT;
      end_cmd = CMD_NOP;
    end else if (edge_cnt_q == EDGE_WORD) begin
      end_kind = FRAME_EXACT;
      end_cmd = isr_q;
    end
  end

  always_comb begin
    state_d = state_q;
    rv_d = rv_q;
    edge_cnt_d = edge_cnt_q;
    isr_d = isr_q;
    output_shift_reg_d = output_shift_reg_q;
    pending_d = pending_q;
    lanes_d = lanes_q;
    oe_d = oe_q;
    hold_d = hold_q;
    cmd_valid_d = 1'b0;
    kind_d = kind_q;
    conv_cnt_d = conv_cnt_q;
    readback_d = readback_q;
    wr_en = 1'b0;
    wr_val = rd_half;
    unique case (state_q)
      ST_ACQ: begin
        rv_d = 1'b1;
        if (cs_fall) begin
          state_d = ST_FRAME;
          rv_d = 1'b0;
          edge_cnt_d = '0;
          output_shift_reg_d = pending_q;
          oe_d = lane_enable;
          hold_d = CMD_NOP;
          // A readback is good for the one frame that follows it
          readback_d = '0;
        end
      end
      ST_FRAME: begin
        // Mode 1 raises ready_valid_out once a full word has been clocked
        rv_d = rv_mode && (edge_cnt_q >= EDGE_WORD);
        if (capture_edge) begin
          if (edge_cnt_q != EDGE_SAT) begin
            edge_cnt_d = edge_cnt_q + 1'b1;
          end
          // Older bits fall off the top, so a long frame keeps its last 32
          isr_d = {isr_q[WORD_W-2:0], pins_level.serial_in};
        end
        if (launch_edge) begin
          lanes_d = {NUM_LANES{output_shift_reg_q[WORD_W-1]}} & oe_q;
          output_shift_reg_d = {output_shift_reg_q[WORD_W-2:0], 1'b0};
        end
        if (cs_rise) begin
          state_d = ST_CONV;
          oe_d = '0;
          lanes_d = '0;
          rv_d = 1'b0;
          conv_cnt_d = '0;
          cmd_valid_d = 1'b1;
          kind_d = end_kind;
          hold_d = end_cmd;
        end
      end
      ST_CONV: begin
        // Select edges are not looked at here at all
        rv_d = 1'b0;
        conv_cnt_d = conv_cnt_q + 1'b1;
        // The held command acts once, in the first conversion cycle
        if (cmd_valid_q) begin
          unique case (hold_q.opcode)
            OP_CLEAR_HALF_WORD_OP: begin
              wr_en = 1'b1;
              wr_val = rd_half & ~hold_q.data;
            end
            OP_WRITE_HALF_WORD_OP: begin
              wr_en = 1'b1;
              wr_val = hold_q.data;
            end
            OP_HALF_WORD_READ: begin
              readback_d = rd_half;
            end
            OP_READ_BYTE: begin
              // Byte read keeps the real address LSB to pick the byte
              if (hold_q.addr[0]) begin
                readback_d = {8'h00, rd_half[15:8]};
              end else begin
                readback_d = {8'h00, rd_half[7:0]};
              end
            end
            default: begin
              readback_d = readback_q;
            end
          endcase
        end
        if (conv_cnt_q == CONV_LAST) begin
          state_d = ST_ACQ;
          rv_d = 1'b1;
          // Result and readback are taken together so the word is never torn
          pending_d = {conv_data, readback_q};
        end
      end
      default: begin
        state_d = ST_ACQ;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_ACQ;
      rv_q <= 1'b0;
      edge_cnt_q <= '0;
      isr_q <= '0;
      output_shift_reg_q <= '0;
      pending_q <= '0;
      lanes_q <= '0;
      oe_q <= '0;
      hold_q <= CMD_NOP;
      cmd_valid_q <= 1'b0;
      kind_q <= FRAME_SHORT;
      conv_cnt_q <= '0;
      readback_q <= '0;
    end else begin
      state_q <= state_d;
      rv_q <= rv_d;
      edge_cnt_q <= edge_cnt_d;
      isr_q <= isr_d;
      output_shift_reg_q <= output_shift_reg_d;
      pending_q <= pending_d;
      lanes_q <= lanes_d;
      oe_q <= oe_d;
      hold_q <= hold_d;
      cmd_valid_q <= cmd_valid_d;
      kind_q <= kind_d;
      conv_cnt_q <= conv_cnt_d;
      readback_q <= readback_d;
    end
  end

  // Array kept out of the main state group; one entry moves per write cycle, all 256 at reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (wr_en) begin
      regs_q[wr_idx] <= wr_val;
    end
  end

  assign ready_valid_out = rv_q;
  assign serial_out_lanes = lanes_q;
  assign serial_out_oe = oe_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_word = hold_q;
  assign frame_kind = kind_q;

endmodule : adc_serial_frame_interface

`default_nettype wire

// ---- test/adc_frame_asserts.sv ----
// Checker for the serial frame interface, bound to its top module.
// Assumes lane_enable is held steady across each frame.
`timescale 1ns/100ps
`default_nettype none
module adc_frame_asserts
  import adc_frame_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convert_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic [NUM_LANES-1:0] lane_enable,
  input wire logic [HALF_W-1:0] conv_data,
  input wire logic ready_valid_out,
  input wire logic [NUM_LANES-1:0] serial_out_lanes,
  input wire logic [NUM_LANES-1:0] serial_out_oe,
  input wire logic cmd_valid,
  input wire cmd_t cmd_word,
  input wire frame_kind_t frame_kind
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [NUM_LANES-1:0] on_lanes;
  assign on_lanes = serial_out_lanes & serial_out_oe;
  frame_start_a: assert property ($fell(convert_select_n) && ready_valid_out |-> ##[1:5] !ready_valid_out)
    else $error("ready_valid_out did not drop at frame start");
  lane_claim_a: assert property ($fell(convert_select_n) && ready_valid_out |-> ##[1:5] serial_out_oe == lane_enable)
    else $error("output enables do not follow lane_enable");
  lanes_agree_a: assert property (serial_out_oe != 0 |-> on_lanes == 0 || on_lanes == serial_out_oe)
    else $error("enabled lanes carry different bits");
  idle_lanes_a: assert property ((serial_out_lanes & ~serial_out_oe) == 0)
    else $error("undriven lane not at zero");
  lane_release_a: assert property ($rose(convert_select_n) |-> ##6 serial_out_oe == 0)
    else $error("lanes still driven after frame end");
  cmd_hand_a: assert property (cmd_valid |-> $past(convert_select_n, 3) && !ready_valid_out)
    else $error("command issued without frame end");
  short_nop_a: assert property (cmd_valid && frame_kind == FRAME_SHORT |-> cmd_word == CMD_NOP)
    else $error("short frame command not dropped");
  conv_low_a: assert property (cmd_valid |=> !ready_valid_out [*8])
    else $error("ready_valid_out rose early in conversion");
  conv_end_a: assert property (cmd_valid |-> ##[160:190] ready_valid_out)
    else $error("conversion did not finish in time");
  conv_deaf_a: assert property ($fell(convert_select_n) && !ready_valid_out |-> ##1 (serial_out_oe == 0) [*6])
    else $error("select edge acted on during conversion");
  cover property (cmd_valid && frame_kind == FRAME_SHORT);
  cover property (cmd_valid && frame_kind == FRAME_EXACT);
  cover property (cmd_valid && frame_kind == FRAME_LONG);
endmodule : adc_frame_asserts
`default_nettype wire

// ---- test/host_model.sv ----
// Host controller model: frames, serial clock and command bits on the link.
// Assumes the caller waits for each task; lane 0 must be enabled to read data.
`timescale 1ns/100ps
`default_nettype none
module host_model
  import adc_frame_pkg::*;
(
  input wire logic sys_clk,
  output logic convert_select_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic ready_valid_out,
  input wire logic [NUM_LANES-1:0] serial_out_lanes,
  input wire logic [NUM_LANES-1:0] serial_out_oe
);
  initial begin
    convert_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : ticks
  // Half period of ten system cycles gives the 80 ns serial clock
  task automatic frame(input int nbits, input logic [63:0] tx, output logic [31:0] rx);
    int k;
    k = 0;
    rx = '0;
    while (ready_valid_out !== 1'b1 && k < 400) begin
      ticks(1);
      k++;
    end
    convert_select_n = 1'b0;
    ticks(10);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_clk = 1'b1;
      serial_in = tx[i];
      ticks(10);
      if (nbits - 1 - i < 32) rx = {rx[30:0], serial_out_oe[0] ? serial_out_lanes[0] : ~rx[0]};
      serial_clk = 1'b0;
      ticks(10);
    end
    // Released data line shows the inverse so a stale bit is never mistaken for data
    serial_in = ~serial_in;
    convert_select_n = 1'b1;
  endtask : frame
  task automatic glitch();
    ticks(20);
    convert_select_n = 1'b0;
    ticks(10);
    convert_select_n = 1'b1;
  endtask : glitch
endmodule : host_model
`default_nettype wire

// ---- test/adc_serial_frame_interface_tb.sv ----
// Self-checking bench: host model drives frames, tasks judge commands and readback.
// Assumes conv_data is held constant so every result word is predictable.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_frame_interface_tb;
  import adc_frame_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, cs_n, sclk, sdi, rv, cv;
  logic [NUM_LANES-1:0] lanes, oe;
  cmd_t cw;
  frame_kind_t fk;
  logic [31:0] rx;
  int n_mismatch = 0, n_compared = 0;
  int n_rv_rise = 0;
  logic rv_prev = 1'b0, cs_prev = 1'b1;
  always #2 sys_clk = ~sys_clk;
  // Counts ready_valid_out rises inside a frame that was already running
  always @(posedge sys_clk) begin
    if (cs_n === 1'b0 && cs_prev === 1'b0 && rv === 1'b1 && rv_prev === 1'b0) begin
      n_rv_rise <= n_rv_rise + 1;
    end
    rv_prev <= rv;
    cs_prev <= cs_n;
  end
  adc_serial_frame_interface dut_u (.sys_clk(sys_clk), .reset(reset), .convert_select_n(cs_n),
    .serial_clk(sclk), .serial_in(sdi), .lane_enable(4'h5), .conv_data(16'h1234),
    .ready_valid_out(rv), .serial_out_lanes(lanes), .serial_out_oe(oe), .cmd_valid(cv),
    .cmd_word(cw), .frame_kind(fk));
  host_model host_u (.sys_clk(sys_clk), .convert_select_n(cs_n), .serial_clk(sclk),
    .serial_in(sdi), .ready_valid_out(rv), .serial_out_lanes(lanes), .serial_out_oe(oe));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] cmd(input logic [4:0] op, input logic [8:0] a, input logic [15:0] d);
    return {op, 2'b00, a, d};
  endfunction : cmd
  task automatic frame_cmd(input int n, input logic [63:0] tx, input frame_kind_t kind);
    int k;
    k = 0;
    host_u.frame(n, tx, rx);
    while (cv !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(32'(cv), 32'h0000_0001);
    chk(cw, kind == FRAME_SHORT ? CMD_NOP : tx[31:0]);
    chk(32'(fk), 32'(kind));
  endtask : frame_cmd
  task automatic t_write_read();
    frame_cmd(32, cmd(OP_WRITE_HALF_WORD_OP, 9'h005, 16'ha5c3), FRAME_EXACT);
    frame_cmd(32, cmd(OP_HALF_WORD_READ, 9'h004, 16'h0000), FRAME_EXACT);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(rx, 32'h1234_a5c3);
    $display("write and half-word read done");
  endtask : t_write_read
  task automatic t_clear_byte();
    frame_cmd(32, cmd(OP_CLEAR_HALF_WORD_OP, 9'h004, 16'h00ff), FRAME_EXACT);
    frame_cmd(32, cmd(OP_READ_BYTE, 9'h005, 16'h0000), FRAME_EXACT);
    frame_cmd(32, cmd(OP_HALF_WORD_READ, 9'h004, 16'h0000), FRAME_EXACT);
    chk(rx, 32'h1234_00a5);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(rx, 32'h1234_a500);
    $display("clear and byte read done");
  endtask : t_clear_byte
  task automatic t_short();
    int n;
    n = 0;
    frame_cmd(20, cmd(OP_WRITE_HALF_WORD_OP, 9'h004, 16'hffff), FRAME_SHORT);
    chk(rx, 32'h0001_2340);
    host_u.glitch();
    repeat (250) begin
      @(posedge sys_clk);
      #1;
      if (cv === 1'b1) n++;
    end
    chk(n, 0);
    frame_cmd(32, cmd(OP_HALF_WORD_READ, 9'h004, 16'h0000), FRAME_EXACT);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(rx, 32'h1234_a500);
    $display("short frame done");
  endtask : t_short
  task automatic t_long();
    frame_cmd(40, {8'hff, cmd(OP_HALF_WORD_READ, 9'h004, 16'h0000)}, FRAME_LONG);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(rx, 32'h1234_a500);
    $display("long frame done");
  endtask : t_long
  task automatic t_rv_mode();
    chk(n_rv_rise, 0);
    frame_cmd(32, cmd(OP_WRITE_HALF_WORD_OP, 9'h001, 16'h0001), FRAME_EXACT);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(n_rv_rise, 1);
    frame_cmd(32, cmd(OP_CLEAR_HALF_WORD_OP, 9'h000, 16'h0001), FRAME_EXACT);
    frame_cmd(32, CMD_NOP, FRAME_EXACT);
    chk(n_rv_rise, 2);
    $display("ready/valid protocol modes done");
  endtask : t_rv_mode
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_write_read();
    t_clear_byte();
    t_short();
    t_long();
    t_rv_mode();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : adc_serial_frame_interface_tb
bind adc_serial_frame_interface adc_frame_asserts chk_u (.sys_clk(sys_clk), .reset(reset),
  .convert_select_n(convert_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
  .lane_enable(lane_enable), .conv_data(conv_data), .ready_valid_out(ready_valid_out),
  .serial_out_lanes(serial_out_lanes), .serial_out_oe(serial_out_oe), .cmd_valid(cmd_valid),
  .cmd_word(cmd_word), .frame_kind(frame_kind));
`default_nettype wire
